/* File: src/bsc_pkg.sv */
// Constants, register map and state types of the burst seat clean block.
// Assumes a 100 MHz system clock and an AXI4-Lite register bus.
//
// Behaviour
// - Burst clean may only be enabled with 2 or 3 solenoids fitted and a successful auto setup.
// - Four presses of menu-select, then confirm while indicator 4 flashes, toggle the enable.
// - The enable is also a parameter written over the serial configuration link.
// - The enable is cleared in the factory default state.
// - A manual restore to factory defaults clears the enable even if it was set.
// - While enabled, a rising upper-lift or lower-push request energises its own solenoid.
// - The solenoid is de-energised as soon as the target reaches that seat's energised position.
// - Each completed pulse gives a two-second handshake on the feedback output and the indicator.
// - Without the upper-lift sensor the pulse ends after the stored push stroke time plus a margin.
// - The fail-safe output drops for codes 16, 19 to 27 and 29 to 31, not for 15, 17, 18 or 28.
// - The main-valve de-energised signal drops only for codes 16, 19 to 22 and 31.
// - The fail-safe output is high whenever no error is present.
package bsc_pkg;

    // ==========================================================
    // Register map
    localparam int            BSC_ADDR_W       = 8;
    localparam logic [7:0]    BSC_OFF_CTRL     = 8'h00;
    localparam logic [7:0]    BSC_OFF_STATUS   = 8'h04;
    localparam logic [7:0]    BSC_OFF_IRQ_STAT = 8'h08;
    localparam logic [7:0]    BSC_OFF_IRQ_MASK = 8'h0C;
    localparam logic [7:0]    BSC_OFF_STROKE   = 8'h10;
    localparam int            BSC_IRQ_DONE     = 0;
    localparam int            BSC_IRQ_FAIL     = 1;
    localparam int            BSC_IRQ_W        = 2;
    localparam logic [31:0]   BSC_STROKE_RST   = 32'h05F5_E100;
    localparam logic [1:0]    BSC_RESP_OKAY    = 2'h0;
    localparam logic [1:0]    BSC_RESP_SLVERR  = 2'h2;

    // ==========================================================
    // Timing
    localparam int            BSC_CLK_KHZ      = 100_000;
    localparam int            BSC_HANDSHAKE_MS = 2000;
    localparam int            BSC_HANDSHAKE_CYC = BSC_HANDSHAKE_MS * BSC_CLK_KHZ;
    localparam int            BSC_MARGIN_MS    = 100;
    localparam int            BSC_MARGIN_CYC   = BSC_MARGIN_MS * BSC_CLK_KHZ;

    // ==========================================================
    // Setup, menu and error codes
    localparam logic [1:0]    BSC_SOL_MIN      = 2'h2;
    localparam logic [2:0]    BSC_MENU_BURST   = 3'h4;
    localparam logic [4:0]    BSC_ERR_TARGET   = 5'h10;
    localparam logic [4:0]    BSC_ERR_SEATSNS  = 5'h13;
    localparam logic [4:0]    BSC_ERR_SNSMISS  = 5'h16;
    localparam logic [4:0]    BSC_ERR_HWFAULT  = 5'h1B;
    localparam logic [4:0]    BSC_ERR_BUTTON   = 5'h1D;
    localparam logic [4:0]    BSC_ERR_STOP     = 5'h1F;

    typedef enum logic [1:0] {ST_IDLE, ST_PULSE, ST_HANDSHAKE} bsc_state_e;

endpackage : bsc_pkg

/* File: src/bsc_menu_buttons.sv */
// Menu selection on the two control-board buttons.
// Assumes button levels already debounced and synchronous to clock.
`timescale 1ns/10ps
module bsc_menu_buttons
    import bsc_pkg::*;
(
    input  wire logic       clock,
    input  wire logic       rst_n,
    input  wire logic       selectBtn,
    input  wire logic       enterBtn,
    output logic            togglePulse,
    output logic [2:0]      menuIndex
);
    logic       selPrevReg, selPrevNext, entPrevReg, entPrevNext;
    logic       toggleReg, toggleNext;
    logic [2:0] indexReg, indexNext;

    // ==========================================================
    // Press counting
    always_comb begin
        selPrevNext = selectBtn;
        entPrevNext = enterBtn;
        toggleNext  = 1'b0;
        indexNext   = indexReg;
        if (enterBtn && !entPrevReg) begin
            toggleNext = (indexReg == BSC_MENU_BURST);
            indexNext  = 3'h0;
        end else if (selectBtn && !selPrevReg) begin
            indexNext = indexReg + 3'h1;
        end
    end

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            selPrevReg <= 1'b0;
            entPrevReg <= 1'b0;
            toggleReg  <= 1'b0;
            indexReg   <= 3'h0;
        end else begin
            selPrevReg <= selPrevNext;
            entPrevReg <= entPrevNext;
            toggleReg  <= toggleNext;
            indexReg   <= indexNext;
        end
    end

    assign togglePulse = toggleReg;
    assign menuIndex   = indexReg;

    a_toggle_menu: assert property (@(posedge clock) disable iff (!rst_n)
        togglePulse |-> $past(indexReg) == BSC_MENU_BURST && $past(enterBtn))
        else $error("toggle without menu slot 4 and confirm");

endmodule : bsc_menu_buttons

/* File: src/bsc_failsafe.sv */
// Fail-safe valve-state and main-valve de-energised outputs from the error code.
// Assumes the error code input is synchronous and valid while errActive is high.
`timescale 1ns/10ps
module bsc_failsafe
    import bsc_pkg::*;
(
    input  wire logic       clock,
    input  wire logic       rst_n,
    input  wire logic       errActive,
    input  wire logic [4:0] errCode,
    output logic            failSafe,
    output logic            mainDeen
);
    logic fsReg, fsNext, mdReg, mdNext;

    function automatic logic drops_digital(input logic [4:0] c);
        return (c == BSC_ERR_TARGET) || (c >= BSC_ERR_SEATSNS && c <= BSC_ERR_HWFAULT)
            || (c >= BSC_ERR_BUTTON && c <= BSC_ERR_STOP);
    endfunction : drops_digital

    function automatic logic drops_asi(input logic [4:0] c);
        return (c == BSC_ERR_TARGET) || (c >= BSC_ERR_SEATSNS && c <= BSC_ERR_SNSMISS)
            || (c == BSC_ERR_STOP);
    endfunction : drops_asi

    always_comb begin
        fsNext = !(errActive && drops_digital(errCode));
        mdNext = !(errActive && drops_asi(errCode));
    end

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            fsReg <= 1'b1;
            mdReg <= 1'b1;
        end else begin
            fsReg <= fsNext;
            mdReg <= mdNext;
        end
    end

    assign failSafe = fsReg;
    assign mainDeen = mdReg;

    a_fs_drop: assert property (@(posedge clock) disable iff (!rst_n)
        errActive && (errCode inside {5'h10, [5'h13:5'h1B], [5'h1D:5'h1F]}) |=> !failSafe)
        else $error("fail-safe did not drop");
    a_fs_keep: assert property (@(posedge clock) disable iff (!rst_n)
        errActive && (errCode inside {5'h0F, 5'h11, 5'h12, 5'h1C}) |=> failSafe)
        else $error("fail-safe dropped on a neutral code");
    a_asi_sel: assert property (@(posedge clock) disable iff (!rst_n)
        errActive |=> mainDeen == !($past(errCode) inside {5'h10, [5'h13:5'h16], 5'h1F}))
        else $error("main de-energised signal wrong");
    a_fs_noerr: assert property (@(posedge clock) disable iff (!rst_n)
        !errActive |=> failSafe && mainDeen)
        else $error("outputs low without error");

endmodule : bsc_failsafe

/* File: src/bsc_burst_clean.sv */
// Burst seat clean sequencer with AXI4-Lite registers and interrupt.
// Assumes all inputs synchronous to clock; setup results come from the setup logic.
//
// The implementer's own choices: the AXI4-Lite slave port and the address map.
`timescale 1ns/10ps
module bsc_burst_clean
    import bsc_pkg::*;
#(
    parameter int HANDSHAKE_CYC = BSC_HANDSHAKE_CYC,
    parameter int MARGIN_CYC    = BSC_MARGIN_CYC
)(
    input  wire logic                  clock,
    input  wire logic                  rst_n,
    input  wire logic [bsc_pkg::BSC_ADDR_W-1:0] s_axi_awaddr,
    input  wire logic                  s_axi_awvalid,
    output logic                       s_axi_awready,
    input  wire logic [31:0]           s_axi_wdata,
    input  wire logic [3:0]            s_axi_wstrb,
    input  wire logic                  s_axi_wvalid,
    output logic                       s_axi_wready,
    output logic [1:0]                 s_axi_bresp,
    output logic                       s_axi_bvalid,
    input  wire logic                  s_axi_bready,
    input  wire logic [bsc_pkg::BSC_ADDR_W-1:0] s_axi_araddr,
    input  wire logic                  s_axi_arvalid,
    output logic                       s_axi_arready,
    output logic [31:0]                s_axi_rdata,
    output logic [1:0]                 s_axi_rresp,
    output logic                       s_axi_rvalid,
    input  wire logic                  s_axi_rready,
    input  wire logic [1:0]            solenoidCount,
    input  wire logic                  setupOk,
    input  wire logic                  noUslSensor,
    input  wire logic                  factoryRestore,
    input  wire logic                  selectBtn,
    input  wire logic                  enterBtn,
    input  wire logic                  reqUsl,
    input  wire logic                  reqLsp,
    input  wire logic                  posUslReached,
    input  wire logic                  posLspReached,
    input  wire logic                  errActive,
    input  wire logic [4:0]            errCode,
    output logic                       solUsl,
    output logic                       solLsp,
    output logic                       handshakeOut,
    output logic                       indicatorOut,
    output logic                       failSafe,
    output logic                       mainDeen,
    output logic                       irq
);
    import bsc_pkg::*;

    // ==========================================================
    // Declarations
    logic                    awHeldReg, awHeldNext, wHeldReg, wHeldNext;
    logic [BSC_ADDR_W-1:0]   awAddrReg, awAddrNext;
    logic [31:0]             wDataReg, wDataNext;
    logic                    wLane0Reg, wLane0Next;
    logic                    awRdyReg, awRdyNext, wRdyReg, wRdyNext;
    logic                    bValReg, bValNext, arRdyReg, arRdyNext, rValReg, rValNext;
    logic [1:0]              bRespReg, bRespNext, rRespReg, rRespNext;
    logic [31:0]             rDataReg, rDataNext;
    logic                    doWrite, wrCtrl;
    logic                    burstEnReg, burstEnNext;
    logic [31:0]             strokeReg, strokeNext;
    logic [BSC_IRQ_W-1:0]    irqStatReg, irqStatNext, irqMaskReg, irqMaskNext;
    logic                    irqReg, irqNext;
    bsc_state_e              stateReg, stateNext;
    logic                    seatLspReg, seatLspNext;
    logic [31:0]             cntReg, cntNext;
    logic                    uslPrevReg, lspPrevReg;
    logic                    solUslReg, solUslNext, solLspReg, solLspNext;
    logic                    hsReg, hsNext, ledReg, ledNext;
    logic                    fsPrevReg;
    logic                    allowed, riseUsl, riseLsp, reached, timedOut, pulseDone;
    logic                    btnToggle;
    logic [2:0]              menuIndex;

    function automatic logic addr_is(input logic [BSC_ADDR_W-1:0] a,
                                     input logic [7:0] off);
        return {a[BSC_ADDR_W-1:2], 2'h0} == off;
    endfunction : addr_is

    // ==========================================================
    // Submodules
    bsc_menu_buttons u_menu (
        .clock       (clock),
        .rst_n       (rst_n),
        .selectBtn   (selectBtn),
        .enterBtn    (enterBtn),
        .togglePulse (btnToggle),
        .menuIndex   (menuIndex)
    );

    bsc_failsafe u_fs (
        .clock     (clock),
        .rst_n     (rst_n),
        .errActive (errActive),
        .errCode   (errCode),
        .failSafe  (failSafe),
        .mainDeen  (mainDeen)
    );

    // ==========================================================
    // AXI4-Lite slave
    always_comb begin
        awHeldNext = awHeldReg;
        wHeldNext  = wHeldReg;
        awAddrNext = awAddrReg;
        wDataNext  = wDataReg;
        wLane0Next = wLane0Reg;
        bValNext   = bValReg;
        bRespNext  = bRespReg;
        rValNext   = rValReg;
        rRespNext  = rRespReg;
        rDataNext  = rDataReg;
        doWrite    = awHeldReg && wHeldReg && !bValReg;
        if (s_axi_awvalid && awRdyReg) begin
            awHeldNext = 1'b1;
            awAddrNext = s_axi_awaddr;
        end
        if (s_axi_wvalid && wRdyReg) begin
            wHeldNext  = 1'b1;
            wDataNext  = s_axi_wdata;
            wLane0Next = s_axi_wstrb[0];
        end
        if (doWrite) begin
            awHeldNext = 1'b0;
            wHeldNext  = 1'b0;
            bValNext   = 1'b1;
            bRespNext  = (awAddrReg[BSC_ADDR_W-1:2] <= BSC_OFF_STROKE[7:2])
                         ? BSC_RESP_OKAY : BSC_RESP_SLVERR;
        end else if (bValReg && s_axi_bready) begin
            bValNext = 1'b0;
        end
        if (s_axi_arvalid && arRdyReg) begin
            rValNext  = 1'b1;
            rRespNext = BSC_RESP_OKAY;
            rDataNext = 32'h0;
            if (addr_is(s_axi_araddr, BSC_OFF_CTRL)) begin
                rDataNext[0] = burstEnReg;
            end else if (addr_is(s_axi_araddr, BSC_OFF_STATUS)) begin
                rDataNext[10:0] = {menuIndex, 1'b0, mainDeen, failSafe, hsReg,
                                   solLspReg, solUslReg, allowed, burstEnReg};
            end else if (addr_is(s_axi_araddr, BSC_OFF_IRQ_STAT)) begin
                rDataNext[BSC_IRQ_W-1:0] = irqStatReg;
            end else if (addr_is(s_axi_araddr, BSC_OFF_IRQ_MASK)) begin
                rDataNext[BSC_IRQ_W-1:0] = irqMaskReg;
            end else if (addr_is(s_axi_araddr, BSC_OFF_STROKE)) begin
                rDataNext = strokeReg;
            end else begin
                rRespNext = BSC_RESP_SLVERR;
            end
        end else if (rValReg && s_axi_rready) begin
            rValNext = 1'b0;
        end
        awRdyNext = !awHeldNext && !bValNext;
        wRdyNext  = !wHeldNext && !bValNext;
        arRdyNext = !rValNext;
    end

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            awHeldReg <= 1'b0;
            wHeldReg  <= 1'b0;
            awAddrReg <= '0;
            wDataReg  <= 32'h0;
            wLane0Reg <= 1'b0;
            awRdyReg  <= 1'b0;
            wRdyReg   <= 1'b0;
            bValReg   <= 1'b0;
            bRespReg  <= BSC_RESP_OKAY;
            arRdyReg  <= 1'b0;
            rValReg   <= 1'b0;
            rRespReg  <= BSC_RESP_OKAY;
            rDataReg  <= 32'h0;
        end else begin
            awHeldReg <= awHeldNext;
            wHeldReg  <= wHeldNext;
            awAddrReg <= awAddrNext;
            wDataReg  <= wDataNext;
            wLane0Reg <= wLane0Next;
            awRdyReg  <= awRdyNext;
            wRdyReg   <= wRdyNext;
            bValReg   <= bValNext;
            bRespReg  <= bRespNext;
            arRdyReg  <= arRdyNext;
            rValReg   <= rValNext;
            rRespReg  <= rRespNext;
            rDataReg  <= rDataNext;
        end
    end

    // ==========================================================
    // Control registers and interrupt
    always_comb begin
        allowed     = setupOk && (solenoidCount >= BSC_SOL_MIN);
        wrCtrl      = doWrite && wLane0Reg && addr_is(awAddrReg, BSC_OFF_CTRL);
        burstEnNext = burstEnReg;
        if (btnToggle) begin
            burstEnNext = !burstEnReg;
        end
        if (wrCtrl) begin
            burstEnNext = wDataReg[0];
        end
        if (!allowed || factoryRestore) begin
            burstEnNext = 1'b0;
        end
        strokeNext  = strokeReg;
        irqMaskNext = irqMaskReg;
        irqStatNext = irqStatReg;
        if (doWrite && addr_is(awAddrReg, BSC_OFF_STROKE)) begin
            strokeNext = wDataReg;
        end
        if (doWrite && wLane0Reg && addr_is(awAddrReg, BSC_OFF_IRQ_MASK)) begin
            irqMaskNext = wDataReg[BSC_IRQ_W-1:0];
        end
        if (doWrite && wLane0Reg && addr_is(awAddrReg, BSC_OFF_IRQ_STAT)) begin
            irqStatNext = irqStatReg & ~wDataReg[BSC_IRQ_W-1:0];
        end
        if (pulseDone) begin
            irqStatNext[BSC_IRQ_DONE] = 1'b1;
        end
        if (fsPrevReg && !failSafe) begin
            irqStatNext[BSC_IRQ_FAIL] = 1'b1;
        end
        irqNext = |(irqStatNext & irqMaskNext);
    end

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            burstEnReg <= 1'b0;
            strokeReg  <= BSC_STROKE_RST;
            irqMaskReg <= '0;
            irqStatReg <= '0;
            irqReg     <= 1'b0;
            fsPrevReg  <= 1'b1;
        end else begin
            burstEnReg <= burstEnNext;
            strokeReg  <= strokeNext;
            irqMaskReg <= irqMaskNext;
            irqStatReg <= irqStatNext;
            irqReg     <= irqNext;
            fsPrevReg  <= failSafe;
        end
    end

    // ==========================================================
    // Burst pulse sequencer
    always_comb begin
        riseUsl     = reqUsl && !uslPrevReg;
        riseLsp     = reqLsp && !lspPrevReg;
        reached     = seatLspReg ? posLspReached : posUslReached;
        timedOut    = cntReg >= strokeReg + 32'(MARGIN_CYC);
        pulseDone   = 1'b0;
        stateNext   = stateReg;
        seatLspNext = seatLspReg;
        cntNext     = cntReg;
        solUslNext  = solUslReg;
        solLspNext  = solLspReg;
        hsNext      = hsReg;
        ledNext     = ledReg;
        case (stateReg)
            ST_IDLE: begin
                cntNext = 32'h0;
                if (burstEnReg && (riseUsl || riseLsp)) begin
                    stateNext   = ST_PULSE;
                    seatLspNext = !riseUsl;
                    solUslNext  = riseUsl;
                    solLspNext  = !riseUsl;
                end
            end
            ST_PULSE: begin
                cntNext = cntReg + 32'h1;
                if (noUslSensor ? timedOut : reached) begin
                    pulseDone  = 1'b1;
                    stateNext  = ST_HANDSHAKE;
                    cntNext    = 32'h0;
                    solUslNext = 1'b0;
                    solLspNext = 1'b0;
                    hsNext     = 1'b1;
                    ledNext    = 1'b1;
                end
            end
            ST_HANDSHAKE: begin
                cntNext = cntReg + 32'h1;
                if (cntReg == 32'(HANDSHAKE_CYC - 1)) begin
                    stateNext = ST_IDLE;
                    hsNext    = 1'b0;
                    ledNext   = 1'b0;
                end
            end
            default: begin
                stateNext  = ST_IDLE;
                solUslNext = 1'b0;
                solLspNext = 1'b0;
                hsNext     = 1'b0;
                ledNext    = 1'b0;
            end
        endcase
    end

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            stateReg   <= ST_IDLE;
            seatLspReg <= 1'b0;
            cntReg     <= 32'h0;
            uslPrevReg <= 1'b0;
            lspPrevReg <= 1'b0;
            solUslReg  <= 1'b0;
            solLspReg  <= 1'b0;
            hsReg      <= 1'b0;
            ledReg     <= 1'b0;
        end else begin
            stateReg   <= stateNext;
            seatLspReg <= seatLspNext;
            cntReg     <= cntNext;
            uslPrevReg <= reqUsl;
            lspPrevReg <= reqLsp;
            solUslReg  <= solUslNext;
            solLspReg  <= solLspNext;
            hsReg      <= hsNext;
            ledReg     <= ledNext;
        end
    end

    assign s_axi_awready = awRdyReg;
    assign s_axi_wready  = wRdyReg;
    assign s_axi_bresp   = bRespReg;
    assign s_axi_bvalid  = bValReg;
    assign s_axi_arready = arRdyReg;
    assign s_axi_rdata   = rDataReg;
    assign s_axi_rresp   = rRespReg;
    assign s_axi_rvalid  = rValReg;
    assign solUsl        = solUslReg;
    assign solLsp        = solLspReg;
    assign handshakeOut  = hsReg;
    assign indicatorOut  = ledReg;
    assign irq           = irqReg;

    // ==========================================================
    // Checks
    logic        seenReg;
    logic [31:0] hsLenReg;
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            seenReg  <= 1'b0;
            hsLenReg <= 32'h0;
        end else begin
            seenReg  <= 1'b1;
            hsLenReg <= hsReg ? hsLenReg + 32'h1 : 32'h0;
        end
    end

    default clocking cb @(posedge clock); endclocking
    default disable iff (!rst_n);

    a_enable_allowed: assert property (burstEnReg |-> $past(allowed))
        else $error("enabled without valid setup");
    a_default_clear: assert property (!seenReg |-> !burstEnReg)
        else $error("enable set out of reset");
    a_link_write: assert property (wrCtrl && allowed && !factoryRestore
        |=> burstEnReg == $past(wDataReg[0]))
        else $error("link write did not set enable");
    a_restore_clear: assert property (factoryRestore |=> !burstEnReg)
        else $error("restore left enable set");
    a_rise_energise: assert property (stateReg == ST_IDLE && burstEnReg && riseUsl
        |=> solUsl && !solLsp)
        else $error("upper request did not energise");
    a_reach_release: assert property (stateReg == ST_PULSE && !noUslSensor && reached
        |=> !solUsl && !solLsp && handshakeOut)
        else $error("solenoid held after position reached");
    a_hs_length: assert property ($fell(handshakeOut)
        |-> hsLenReg == 32'(HANDSHAKE_CYC) && !indicatorOut)
        else $error("handshake length wrong");
    a_timed_end: assert property (stateReg == ST_PULSE && noUslSensor
        |-> cntReg <= strokeReg + 32'(MARGIN_CYC))
        else $error("timed pulse overran");
    a_busy_ignore: assert property (stateReg == ST_HANDSHAKE && (riseUsl || riseLsp)
        |=> !solUsl && !solLsp)
        else $error("request taken while busy");

endmodule : bsc_burst_clean

/* File: verification/bsc_plc_model.sv */
// PLC side model: burst request driver and valve position sensor.
// Assumes the control head solenoid outputs as its inputs.
`timescale 1ns/10ps
module bsc_plc_model #(parameter int HOLD = 12)(
    input  wire logic       clock,
    input  wire logic       go,
    input  wire logic       seat,
    input  wire logic [2:0] dly,
    input  wire logic       solUsl,
    input  wire logic       solLsp,
    output logic            reqUsl,
    output logic            reqLsp,
    output logic            posUslReached,
    output logic            posLspReached
);
    int   hold  = 0;
    int   onCnt = 0;
    logic which = 1'h0;
    // ========================================
    // Request held for its minimum time
    always @(posedge clock) begin
        if (go) begin
            hold <= HOLD;
            which <= seat;
        end else if (hold > 0) begin
            hold <= hold - 1;
        end
        onCnt <= (solUsl || solLsp) ? onCnt + 1 : 0;
    end
    assign reqUsl = hold > 0 && !which;
    assign reqLsp = hold > 0 && which;
    assign posUslReached = solUsl && onCnt > dly;
    assign posLspReached = solLsp && onCnt > dly;
endmodule : bsc_plc_model

/* File: verification/tb_top.sv */
// Self-checking bench of the burst seat clean block.
// Assumes the PLC model beside it.
`timescale 1ns/10ps
module tb_top;
    import bsc_pkg::*;
    logic clock, rst_n, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, go, seat;
    logic setupOk, noUslSensor, factoryRestore, selectBtn, enterBtn, reqUsl, reqLsp, irq;
    logic posUslReached, posLspReached, errActive, solUsl, solLsp, handshakeOut;
    logic indicatorOut, failSafe, mainDeen;
    logic [7:0]  s_axi_awaddr, s_axi_araddr;
    logic [31:0] s_axi_wdata, s_axi_rdata, rd;
    logic [3:0]  s_axi_wstrb;
    logic [1:0]  s_axi_bresp, s_axi_rresp, solenoidCount;
    logic [4:0]  errCode;
    logic [2:0]  dly;
    int          n_fail, check_count, n, seed;
    bsc_burst_clean #(.HANDSHAKE_CYC(20), .MARGIN_CYC(5)) DUT (.*);
    bsc_plc_model #(.HOLD(12)) plc (.*);
    // ========================================
    // Checks, bus cycles and verdict
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        check_count++;
        if (seen !== exp) begin
            n_fail++;
            $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask : chk
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        {s_axi_awaddr, s_axi_wdata, s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= {a, d, 3'h7};
        do begin
            @(posedge clock);
            if (s_axi_awready) s_axi_awvalid <= 1'h0;
            if (s_axi_wready) s_axi_wvalid <= 1'h0;
        end while ((s_axi_awvalid && !s_axi_awready) || (s_axi_wvalid && !s_axi_wready));
        do @(posedge clock); while (!s_axi_bvalid);
    endtask : wr
    task automatic rdr(input logic [7:0] a);
        {s_axi_araddr, s_axi_arvalid, s_axi_rready} <= {a, 2'h3};
        do @(posedge clock); while (!s_axi_arready);
        s_axi_arvalid <= 1'h0;
        do @(posedge clock); while (!s_axi_rvalid);
        rd = s_axi_rdata;
    endtask : rdr
    function automatic logic fs(int c);
        return !(c == 16 || (c >= 19 && c <= 27) || c >= 29);
    endfunction : fs
    function automatic logic md(int c);
        return !(c == 16 || (c >= 19 && c <= 22) || c == 31);
    endfunction : md
    task automatic close_out();
        if (n_fail == 0 && check_count > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask : close_out
    initial begin
        clock = 1'h0;
        forever #5 clock = ~clock;
    end
    initial begin
        #200000 n_fail++;
        close_out();
    end
    // ========================================
    // Main sequence
    initial begin
        seed = 32'hFDCCCBB0;
        {rst_n, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
        {s_axi_awaddr, s_axi_araddr, s_axi_wdata, go, seat, dly, errCode, errActive} = '0;
        {noUslSensor, factoryRestore, selectBtn, enterBtn} = '0;
        {s_axi_wstrb, solenoidCount, setupOk} = {4'hF, 2'h1, 1'h1};
        repeat (8) @(posedge clock);
        rst_n <= 1'h1;
        @(posedge clock);
        rdr(BSC_OFF_CTRL);
        chk(rd, 32'h0);
        wr(BSC_OFF_CTRL, 32'h1);
        rdr(BSC_OFF_STATUS);
        chk(rd[0], 1'h0);
        solenoidCount <= 2'h2 + 2'($random(seed) & 1);
        wr(BSC_OFF_CTRL, 32'h1);
        rdr(BSC_OFF_STATUS);
        chk(rd[0], 1'h1);
        for (int i = 0; i < 10; i++) begin
            {selectBtn, enterBtn} <= (i % 2) ? 2'h0 : ((i == 8) ? 2'h1 : 2'h2);
            @(posedge clock);
        end
        rdr(BSC_OFF_STATUS);
        chk(rd[0], 1'h0);
        wr(BSC_OFF_CTRL, 32'h1);
        factoryRestore <= 1'h1;
        @(posedge clock);
        factoryRestore <= 1'h0;
        rdr(BSC_OFF_STATUS);
        chk(rd[0], 1'h0);
        rdr(8'h20);
        chk(s_axi_rresp, BSC_RESP_SLVERR);
        wr(BSC_OFF_CTRL, 32'h1);
        wr(BSC_OFF_IRQ_MASK, 32'h1);
        {go, seat, dly} <= {2'h2, 3'($random(seed))};
        @(posedge clock);
        go <= 1'h0;
        for (n = 0; !handshakeOut && n < 100; n++) @(posedge clock);
        chk({solUsl, indicatorOut}, 2'h1);
        {go, seat} <= 2'h3;
        for (n = 0; handshakeOut; n++) begin
            @(posedge clock);
            go <= 1'h0;
            chk(solLsp, 1'h0);
        end
        chk(n, 32'd20);
        chk(irq, 1'h1);
        wr(BSC_OFF_IRQ_STAT, 32'h1);
        repeat (2) @(posedge clock);
        chk(irq, 1'h0);
        for (int i = 0; i < 33; i++) begin
            {errActive, errCode} <= {i < 32, 5'(i)};
            repeat (2) @(posedge clock);
            chk({failSafe, mainDeen}, (i < 32) ? {fs(i), md(i)} : 2'h3);
        end
        wr(BSC_OFF_STROKE, 32'hA);
        {go, seat, noUslSensor} <= 3'h7;
        @(posedge clock);
        go <= 1'h0;
        for (n = 0; !solLsp && n < 100; n++) @(posedge clock);
        for (n = 0; solLsp && n < 100; n++) @(posedge clock);
        chk(n, 32'd16);
        chk(handshakeOut, 1'h1);
        close_out();
    end
endmodule : tb_top
